// file: common/exc_pkg.sv
package exc_pkg;
    // ******************************
    // apb register map
    // ******************************
    localparam logic [7:0] OFF_SR = 8'h00;
    localparam logic [7:0] OFF_SUP_STACK = 8'h04;
    localparam logic [7:0] OFF_USER_STACK = 8'h08;
    localparam logic [7:0] OFF_TABLE_BASE = 8'h0c;
    localparam logic [7:0] OFF_ASP = 8'h10;
    localparam logic [7:0] OFF_INFO = 8'h14;
    localparam logic [7:0] OFF_VADDR = 8'h18;
    // ******************************
    // status word
    // ******************************
    localparam int SR_S_BIT = 13;
    localparam int SR_T_BIT = 15;
    localparam logic [15:0] SR_RESET = 16'h2700;
    localparam logic [15:0] SR_USER_MASK = 16'h00ff;
    // ******************************
    // vectors and frames
    // ******************************
    localparam logic [7:0] VEC_RESET = 8'h00;
    localparam logic [7:0] VEC_BUS_ERR = 8'h02;
    localparam logic [7:0] VEC_ADDR_ERR = 8'h03;
    localparam logic [7:0] VEC_PRIV = 8'h08;
    localparam logic [7:0] VEC_FORMAT = 8'h0e;
    localparam logic [7:0] VEC_SPURIOUS = 8'h18;
    localparam logic [7:0] VEC_AUTO_BASE = 8'h18;
    localparam logic [7:0] VEC_TRAP_BASE = 8'h20;
    localparam logic [3:0] FMT_SHORT = 4'h0;
    localparam logic [3:0] FMT_LONG = 4'h8;
    localparam logic [2:0] FC_USER_DATA = 3'h1;
    localparam logic [2:0] FC_USER_PROG = 3'h2;
    localparam logic [2:0] FC_SUPER_DATA = 3'h5;
    localparam logic [2:0] FC_SUPER_PROG = 3'h6;

    typedef enum logic [2:0] {
        EXK_RESET, EXK_INTERNAL, EXK_AUTOVEC, EXK_IRQ_VEC, EXK_TRAP
    } exc_kind_t;

    typedef enum logic [2:0] {
        OP_OTHER, OP_STOP, OP_RESET, OP_SR_WRITE,
        OP_USP_MOVE, OP_SR_READ, OP_CTRL_MOVE, OP_ALT_MOVE
    } insn_op_t;

    // entry address: table base plus four bytes per vector
    function automatic logic [31:0] vector_address(input logic [31:0] base,
                                                   input logic [7:0] num);
        return base + {22'h000000, num, 2'h0};
    endfunction
endpackage

// file: rtl/vector_resolver.sv
`timescale 1ns/10ps
module vector_resolver (
    input wire exc_pkg::exc_kind_t kind, // exception source class
    input wire logic [7:0] vec_in, // internal or acknowledged vector
    input wire logic [2:0] irq_level, // autovector priority level
    input wire logic iack_berr, // bus error during acknowledge
    input wire logic [3:0] trap_n, // trap operand
    output logic [7:0] vec_num, // resolved vector number
    output logic program_space // fetch from program space
);
    always_comb begin
        vec_num = vec_in;
        program_space = 1'b0;
        case (kind)
            exc_pkg::EXK_RESET: begin
                // reset entry spans the stack word pair and the pc word pair
                vec_num = exc_pkg::VEC_RESET;
                program_space = 1'b1;
            end
            exc_pkg::EXK_AUTOVEC: begin
                vec_num = exc_pkg::VEC_AUTO_BASE + {5'h00, irq_level};
            end
            exc_pkg::EXK_TRAP: begin
                vec_num = exc_pkg::VEC_TRAP_BASE + {4'h0, trap_n};
            end
            default: begin
                vec_num = vec_in;
            end
        endcase
        // a faulted acknowledge never trusts the bus value
        if ((kind == exc_pkg::EXK_AUTOVEC || kind == exc_pkg::EXK_IRQ_VEC) && iack_berr) begin
            vec_num = exc_pkg::VEC_SPURIOUS;
        end
    end
endmodule

// file: rtl/exception_privilege_unit.sv
`timescale 1ns/10ps
// How it works
// - status supervisor bit set means supervisor privilege, all instructions run
// - supervisor bit clear means user privilege
// - supervisor bus cycles are classified as supervisor references
// - user bus cycles are classified as user references
// - active stack pointer is supervisor or user pointer by privilege
// - user mode refuses stop, reset, status write, user pointer alternate_space_move
// - vm variant also guards status read, control and alternate alternate_space_move
// - only exception processing lifts user mode to supervisor
// - exception entry saves the status word then sets supervisor
// - vector zero spans four words, all others two
// - reset vector from program space, others from data space
// - bus error on interrupt acknowledge uses vector 24
// - autovector levels one to seven use vectors 25 to 31
// - trap n uses vector 32 plus n
// - vector 14 is format error only on vm variant
// - frame format 0000 short, 1000 long, others reserved
// - vm variant places the vector table at the table base
// - entry clears trace after copying the status word
// - all but reset push program counter and saved status
module exception_privilege_unit #(
    parameter bit VM_VARIANT = 1'b1
) (
    input wire logic pclk, // processor clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb write
    input wire logic [31:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic exc_req, // exception request pulse
    input wire exc_pkg::exc_kind_t exc_kind, // class of that request
    input wire logic [7:0] exc_vector, // internal or acknowledged vector
    input wire logic [2:0] irq_level, // autovector level
    input wire logic iack_berr, // acknowledge ended in bus error
    input wire logic [3:0] trap_n, // trap operand
    input wire logic insn_valid, // instruction issue pulse
    input wire exc_pkg::insn_op_t insn_op, // issued instruction class
    input wire logic rte_valid, // return from exception pulse
    input wire logic [3:0] rte_format, // popped frame format
    input wire logic [15:0] rte_sr, // popped status word
    input wire logic bus_program, // current cycle fetches program
    output logic supervisor, // supervisor privilege level
    output logic [2:0] fc, // access classification
    output logic [31:0] active_sp, // selected stack pointer
    output logic exc_busy, // exception sequence running
    output logic priv_fault, // privileged op refused, pulse
    output logic format_err, // reserved frame on return, pulse
    output logic push_context, // push pc and saved sr, pulse
    output logic vec_fetch, // fetch vector entry, pulse
    output logic [7:0] vec_num, // current vector number
    output logic [31:0] vec_addr, // current vector address
    output logic vec_program, // vector from program space
    output logic [3:0] frame_format, // stack frame format code
    output logic [15:0] saved_sr // status copy taken on entry
);
    // ******************************
    // state
    // ******************************
    typedef enum logic [1:0] {ST_IDLE, ST_VECTOR, ST_STACK, ST_FETCH} state_t;

    typedef struct packed {
        state_t state;
        logic [15:0] sr;
        logic [31:0] sup_stack;
        logic [31:0] user_stack;
        logic [31:0] table_base;
        logic [15:0] saved_sr;
        exc_pkg::exc_kind_t kind;
        logic [7:0] vec_num;
        logic [31:0] vec_addr;
        logic vec_prog;
        logic [3:0] format;
        logic [31:0] prdata;
        logic slverr;
        logic priv_fault;
        logic format_err;
    } st_t;

    st_t cur;
    st_t next_cur;

    exc_pkg::exc_kind_t start_kind;
    logic [7:0] start_vec_in;
    logic [7:0] res_vec;
    logic res_prog;
    logic exc_start;
    logic priv_hit;
    logic fmt_hit;
    logic wr_en;
    logic rd_setup;
    logic [7:0] reg_off;
    logic addr_hi_ok;

    // ******************************
    // helpers
    // ******************************
    function automatic logic is_privileged(input exc_pkg::insn_op_t op);
        logic p;
        p = 1'b0;
        case (op)
            exc_pkg::OP_STOP, exc_pkg::OP_RESET,
            exc_pkg::OP_SR_WRITE, exc_pkg::OP_USP_MOVE: p = 1'b1;
            exc_pkg::OP_SR_READ, exc_pkg::OP_CTRL_MOVE,
            exc_pkg::OP_ALT_MOVE: p = VM_VARIANT;
            default: p = 1'b0;
        endcase
        return p;
    endfunction

    function automatic logic format_known(input logic [3:0] f);
        return f == exc_pkg::FMT_SHORT || f == exc_pkg::FMT_LONG;
    endfunction

    // ******************************
    // entry arbitration
    // ******************************
    // priority: external request, then privilege fault, then bad frame
    always_comb begin
        priv_hit = insn_valid && !cur.sr[exc_pkg::SR_S_BIT] && is_privileged(insn_op);
        fmt_hit = VM_VARIANT && rte_valid && cur.sr[exc_pkg::SR_S_BIT]
                  && !format_known(rte_format);
        exc_start = (cur.state == ST_IDLE) && (exc_req || priv_hit || fmt_hit);
        start_kind = exc_pkg::EXK_INTERNAL;
        start_vec_in = exc_pkg::VEC_PRIV;
        if (exc_req) begin
            start_kind = exc_kind;
            start_vec_in = exc_vector;
        end else if (fmt_hit) begin
            start_vec_in = exc_pkg::VEC_FORMAT;
        end
    end

    vector_resolver u_resolver (
        .kind(start_kind),
        .vec_in(start_vec_in),
        .irq_level(irq_level),
        .iack_berr(iack_berr),
        .trap_n(trap_n),
        .vec_num(res_vec),
        .program_space(res_prog)
    );

    // ******************************
    // apb decode
    // ******************************
    assign reg_off = paddr[7:0];
    assign addr_hi_ok = paddr[31:8] == 24'h000000;
    assign wr_en = psel && penable && pwrite && !cur.slverr;
    assign rd_setup = psel && !penable;

    // ******************************
    // next state
    // ******************************
    always_comb begin
        next_cur = cur;
        next_cur.priv_fault = 1'b0;
        next_cur.format_err = 1'b0;
        // answer is prepared in setup so it comes from flops in access
        if (rd_setup) begin
            next_cur.prdata = 32'h00000000;
            next_cur.slverr = 1'b0;
            if (!addr_hi_ok) begin
                next_cur.slverr = 1'b1;
            end else if (reg_off == exc_pkg::OFF_SR) begin
                next_cur.prdata = {16'h0000, cur.sr};
            end else if (reg_off == exc_pkg::OFF_SUP_STACK
                         || reg_off == exc_pkg::OFF_USER_STACK) begin
                // only supervisor code may use these two offsets; user code still reads and writes its own pointer through the active pointer offset
                next_cur.slverr = !cur.sr[exc_pkg::SR_S_BIT];
                next_cur.prdata = (reg_off == exc_pkg::OFF_SUP_STACK) ? cur.sup_stack
                                                                       : cur.user_stack;
            end else if (reg_off == exc_pkg::OFF_TABLE_BASE) begin
                next_cur.slverr = !cur.sr[exc_pkg::SR_S_BIT];
                next_cur.prdata = cur.table_base;
            end else if (reg_off == exc_pkg::OFF_ASP) begin
                next_cur.prdata = active_sp;
            end else if (reg_off == exc_pkg::OFF_INFO) begin
                next_cur.prdata = {cur.saved_sr, cur.vec_num, cur.format,
                                   1'b0, cur.kind};
            end else if (reg_off == exc_pkg::OFF_VADDR) begin
                next_cur.prdata = cur.vec_addr;
            end else begin
                next_cur.slverr = 1'b1;
            end
        end
        if (wr_en) begin
            if (reg_off == exc_pkg::OFF_SR) begin
                // user writes reach the low byte only, never the s bit
                if (cur.sr[exc_pkg::SR_S_BIT]) begin
                    next_cur.sr = pwdata[15:0];
                end else begin
                    next_cur.sr = (cur.sr & ~exc_pkg::SR_USER_MASK)
                                  | (pwdata[15:0] & exc_pkg::SR_USER_MASK);
                end
            end else if (reg_off == exc_pkg::OFF_SUP_STACK) begin
                next_cur.sup_stack = pwdata;
            end else if (reg_off == exc_pkg::OFF_USER_STACK) begin
                next_cur.user_stack = pwdata;
            end else if (reg_off == exc_pkg::OFF_TABLE_BASE && VM_VARIANT) begin
                next_cur.table_base = pwdata;
            end else if (reg_off == exc_pkg::OFF_ASP) begin
                if (cur.sr[exc_pkg::SR_S_BIT]) begin
                    next_cur.sup_stack = pwdata;
                end else begin
                    next_cur.user_stack = pwdata;
                end
            end
        end
        case (cur.state)
            ST_IDLE: begin
                if (exc_start) begin
                    next_cur.saved_sr = cur.sr;
                    next_cur.sr[exc_pkg::SR_S_BIT] = 1'b1;
                    next_cur.sr[exc_pkg::SR_T_BIT] = 1'b0;
                    next_cur.kind = start_kind;
                    next_cur.vec_num = res_vec;
                    next_cur.vec_prog = res_prog;
                    next_cur.priv_fault = priv_hit && !exc_req;
                    next_cur.format_err = fmt_hit && !exc_req && !priv_hit;
                    if (start_kind == exc_pkg::EXK_RESET) begin
                        next_cur.sr = exc_pkg::SR_RESET;
                        next_cur.table_base = 32'h00000000;
                    end
                    next_cur.state = ST_VECTOR;
                end else if (rte_valid && cur.sr[exc_pkg::SR_S_BIT]) begin
                    next_cur.sr = rte_sr;
                end
            end
            ST_VECTOR: begin
                next_cur.vec_addr = exc_pkg::vector_address(
                    VM_VARIANT ? cur.table_base : 32'h00000000, cur.vec_num);
                // bus and address errors on the vm variant stack the long frame
                if (VM_VARIANT && (cur.vec_num == exc_pkg::VEC_BUS_ERR
                                   || cur.vec_num == exc_pkg::VEC_ADDR_ERR)) begin
                    next_cur.format = exc_pkg::FMT_LONG;
                end else begin
                    next_cur.format = exc_pkg::FMT_SHORT;
                end
                if (cur.kind == exc_pkg::EXK_RESET) begin
                    next_cur.state = ST_FETCH;
                end else begin
                    next_cur.state = ST_STACK;
                end
            end
            ST_STACK: begin
                next_cur.state = ST_FETCH;
            end
            default: begin
                next_cur.state = ST_IDLE;
            end
        endcase
    end

    // power-up behaves as a reset exception already past the copy step
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur <= '{
                state: ST_VECTOR,
                sr: exc_pkg::SR_RESET,
                sup_stack: 32'h00000000,
                user_stack: 32'h00000000,
                table_base: 32'h00000000,
                saved_sr: exc_pkg::SR_RESET,
                kind: exc_pkg::EXK_RESET,
                vec_num: exc_pkg::VEC_RESET,
                vec_addr: 32'h00000000,
                vec_prog: 1'b1,
                format: exc_pkg::FMT_SHORT,
                prdata: 32'h00000000,
                slverr: 1'b0,
                priv_fault: 1'b0,
                format_err: 1'b0
            };
        end else begin
            cur <= next_cur;
        end
    end

    // ******************************
    // outputs
    // ******************************
    assign supervisor = cur.sr[exc_pkg::SR_S_BIT];
    assign fc = cur.sr[exc_pkg::SR_S_BIT]
                ? (bus_program ? exc_pkg::FC_SUPER_PROG : exc_pkg::FC_SUPER_DATA)
                : (bus_program ? exc_pkg::FC_USER_PROG : exc_pkg::FC_USER_DATA);
    assign active_sp = cur.sr[exc_pkg::SR_S_BIT] ? cur.sup_stack : cur.user_stack;
    assign exc_busy = cur.state != ST_IDLE;
    assign priv_fault = cur.priv_fault;
    assign format_err = cur.format_err;
    assign push_context = cur.state == ST_STACK;
    assign vec_fetch = cur.state == ST_FETCH;
    assign vec_num = cur.vec_num;
    assign vec_addr = cur.vec_addr;
    assign vec_program = cur.vec_prog;
    assign frame_format = cur.format;
    assign saved_sr = cur.saved_sr;
    assign prdata = cur.prdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && cur.slverr;

    // ******************************
    // checks
    // ******************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_entry_steps;
        ##1 (cur.state == ST_VECTOR) ##1 (cur.state != ST_VECTOR);
    endsequence

    a_fc_class: assert property (fc[2] == supervisor)
        else $error("access class disagrees with privilege");
    a_user_stack: assert property (!supervisor |-> active_sp == cur.user_stack)
        else $error("user mode not on user stack");
    a_priv_trap: assert property (
        (cur.state == ST_IDLE) && priv_hit && !exc_req |=>
        priv_fault && supervisor && vec_num == 8'h08)
        else $error("privilege violation not vectored to 8");
    a_no_escape: assert property ($rose(supervisor) |-> $past(exc_start))
        else $error("supervisor entered outside exception");
    a_save_sr: assert property (
        exc_start |=> saved_sr == $past(cur.sr) && supervisor
        && !cur.sr[exc_pkg::SR_T_BIT])
        else $error("status copy or trace clear wrong");
    a_reset_vec: assert property (
        exc_start && start_kind == exc_pkg::EXK_RESET |=>
        vec_program && vec_num == 8'h00 ##1 vec_fetch && vec_addr == 32'h00000000)
        else $error("reset vector not from program space at zero");
    a_spurious: assert property (
        exc_start && exc_req && exc_kind == exc_pkg::EXK_AUTOVEC && iack_berr
        |=> vec_num == 8'h18)
        else $error("spurious vector not 24");
    a_autovec: assert property (
        exc_start && exc_req && exc_kind == exc_pkg::EXK_AUTOVEC && !iack_berr
        |=> vec_num == 8'h18 + {5'h00, $past(irq_level)})
        else $error("autovector number wrong");
    a_trap_vec: assert property (
        exc_start && exc_req && exc_kind == exc_pkg::EXK_TRAP
        |=> vec_num == 8'h20 + {4'h0, $past(trap_n)})
        else $error("trap vector number wrong");
    a_stack_skip: assert property (
        exc_start |-> s_entry_steps ##0
        (push_context == (cur.kind != exc_pkg::EXK_RESET)))
        else $error("context push wrong for exception kind");
    a_vec_addr: assert property (
        cur.state == ST_VECTOR |=>
        vec_addr == $past(cur.table_base) + {22'h000000, $past(cur.vec_num), 2'h0})
        else $error("vector address not base plus four times number");
    a_fmt_err: assert property (
        (cur.state == ST_IDLE) && fmt_hit && !exc_req && !priv_hit |=>
        format_err && vec_num == 8'h0e)
        else $error("reserved frame did not raise format error");
endmodule

// file: verification/vector_table_model.sv
`timescale 1ns/10ps
// ********************
// vector table memory
// ********************
module vector_table_model (
    input wire logic pclk, // processor clock
    input wire logic vec_fetch, // entry fetch pulse
    input wire logic [31:0] vec_addr, // entry byte address
    input wire logic vec_program, // fetch from program space
    output logic [31:0] entry // entry handed back
);
    // entry encodes its own address and space so a wrong fetch shows up
    always_ff @(posedge pclk) begin
        if (vec_fetch) begin
            entry <= {vec_addr[31:1], vec_program};
        end
    end
endmodule

// file: verification/tb_exception_privilege_unit.sv
`timescale 1ns/10ps
module tb_exception_privilege_unit;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, exc_req, iack_berr;
    logic insn_valid, rte_valid, bus_program, supervisor, exc_busy, priv_fault;
    logic format_err, push_context, vec_fetch, vec_program, er;
    logic [31:0] paddr, pwdata, prdata, active_sp, vec_addr, entry, rd, m_base, m_sup_sp, m_usr_sp;
    logic [15:0] rte_sr, saved_sr, m_sr;
    logic [7:0] exc_vector, vec_num, rv;
    logic [3:0] trap_n, rte_format, frame_format;
    logic [2:0] irq_level, fc;
    exc_pkg::exc_kind_t exc_kind;
    exc_pkg::insn_op_t insn_op;
    int err_total, cmp_count, np, nf, npf, nfe;

    exception_privilege_unit dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .exc_req, .exc_kind, .exc_vector, .irq_level, .iack_berr,
        .trap_n, .insn_valid, .insn_op, .rte_valid, .rte_format, .rte_sr, .bus_program,
        .supervisor, .fc, .active_sp, .exc_busy, .priv_fault, .format_err, .push_context,
        .vec_fetch, .vec_num, .vec_addr, .vec_program, .frame_format, .saved_sr);
    vector_table_model mem (.pclk, .vec_fetch, .vec_addr, .vec_program, .entry);

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // ********************
    // bench tasks
    // ********************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("compares=%0d mismatches=%0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 20) begin
            err_total++;
            end_sim();
        end
    endtask
    // pulses last one cycle, so every cycle is looked at until idle
    task automatic watch();
        int i;
        np = 0;
        nf = 0;
        npf = 0;
        nfe = 0;
        for (i = 0; i < 20; i++) begin
            #1;
            if (push_context === 1'b1) np++;
            if (vec_fetch === 1'b1) nf++;
            if (priv_fault === 1'b1) npf++;
            if (format_err === 1'b1) nfe++;
            if (exc_busy === 1'b0) break;
            @(posedge pclk);
        end
        if (i == 20) begin
            err_total++;
            end_sim();
        end
    endtask
    task automatic trig(input logic [2:0] sel);
        @(posedge pclk);
        {exc_req, insn_valid, rte_valid} <= sel;
        @(posedge pclk);
        {exc_req, insn_valid, rte_valid} <= 3'h0;
        watch();
    endtask
    task automatic post(input logic [7:0] num, input logic rst);
        logic [31:0] ea;
        ea = (rst ? 32'h0 : m_base) + {22'h0, num, 2'h0};
        chk(vec_num, num);
        chk(vec_addr, ea);
        chk(entry, {ea[31:1], rst});
        chk(vec_program, rst);
        chk(frame_format, (num == 8'h02 || num == 8'h03) ? exc_pkg::FMT_LONG : exc_pkg::FMT_SHORT);
        chk(np, !rst);
        chk(nf, 1);
        if (!rst) chk(saved_sr, m_sr);
        m_sr = rst ? 16'h2700 : ((m_sr | 16'h2000) & 16'h7fff);
        if (rst) m_base = 32'h0;
        chk(supervisor, 1'b1);
    endtask
    task automatic exc(input exc_pkg::exc_kind_t k, input logic [7:0] v, input logic b,
                       input logic [7:0] num);
        @(posedge pclk);
        exc_kind <= k;
        exc_vector <= v;
        irq_level <= v[2:0];
        trap_n <= v[3:0];
        iack_berr <= b;
        trig(3'h4);
        post(num, k == exc_pkg::EXK_RESET);
    endtask
    task automatic mode(input logic s);
        bus_program <= 1'b1;
        @(posedge pclk);
        #1;
        chk(fc, s ? exc_pkg::FC_SUPER_PROG : exc_pkg::FC_USER_PROG);
        bus_program <= 1'b0;
        #1;
        chk(fc, s ? exc_pkg::FC_SUPER_DATA : exc_pkg::FC_USER_DATA);
        chk(supervisor, s);
        chk(active_sp, s ? m_sup_sp : m_usr_sp);
    endtask

    // ********************
    // main sequence
    // ********************
    initial begin
        {presetn, psel, penable, pwrite, exc_req, iack_berr} = 6'h0;
        {insn_valid, rte_valid, bus_program} = 3'h0;
        {paddr, pwdata, exc_vector, trap_n, irq_level, rte_sr, rte_format} = '0;
        exc_kind = exc_pkg::EXK_RESET;
        insn_op = exc_pkg::OP_OTHER;
        err_total = 0;
        cmp_count = 0;
        m_sr = 16'h2700;
        void'($urandom(83));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        watch();
        post(8'h00, 1'b1);
        apb(1'b0, exc_pkg::OFF_SR, 32'h0);
        chk(rd[15:0], m_sr);
        m_base = $urandom & 32'h00ff_fffc;
        m_sup_sp = $urandom;
        m_usr_sp = $urandom;
        apb(1'b1, exc_pkg::OFF_TABLE_BASE, m_base);
        apb(1'b1, exc_pkg::OFF_SUP_STACK, m_sup_sp);
        apb(1'b1, exc_pkg::OFF_USER_STACK, m_usr_sp);
        mode(1'b1);
        apb(1'b1, exc_pkg::OFF_SR, 32'h0000_a700);
        m_sr = 16'ha700;
        for (int n = 0; n < 16; n++) exc(exc_pkg::EXK_TRAP, n[7:0], 1'b0, 8'd32 + n[7:0]);
        apb(1'b0, exc_pkg::OFF_SR, 32'h0);
        chk(rd[15:0], m_sr);
        for (int l = 1; l < 8; l++) exc(exc_pkg::EXK_AUTOVEC, l[7:0], 1'b0, 8'd24 + l[7:0]);
        exc(exc_pkg::EXK_IRQ_VEC, 8'h40, 1'b1, 8'd24);
        exc(exc_pkg::EXK_AUTOVEC, 8'h05, 1'b1, 8'd24);
        for (int j = 0; j < 4; j++) begin
            rv = 8'h40 + 8'($urandom % 192);
            exc(exc_pkg::EXK_IRQ_VEC, rv, 1'b0, rv);
        end
        exc(exc_pkg::EXK_INTERNAL, 8'h02, 1'b0, 8'h02);
        exc(exc_pkg::EXK_INTERNAL, 8'h03, 1'b0, 8'h03);
        for (int op = 0; op < 8; op++) begin
            apb(1'b1, exc_pkg::OFF_SR, 32'h0);
            m_sr = 16'h0;
            mode(1'b0);
            apb(1'b0, exc_pkg::OFF_SUP_STACK, 32'h0);
            chk(er, 1'b1);
            insn_op <= exc_pkg::insn_op_t'(op);
            trig(3'h2);
            chk(npf, op != 0);
            if (op != 0) post(exc_pkg::VEC_PRIV, 1'b0);
            else chk(supervisor, 1'b0);
        end
        @(posedge pclk);
        rte_format <= 4'h3;
        rte_sr <= 16'h0;
        trig(3'h1);
        chk(nfe, 1);
        post(exc_pkg::VEC_FORMAT, 1'b0);
        apb(1'b0, 32'h0000_001c, 32'h0);
        chk(er, 1'b1);
        exc(exc_pkg::EXK_RESET, 8'h00, 1'b0, 8'h00);
        end_sim();
    end
endmodule
